// ===== include/esob_pkg.sv
// shared constants and types of the error and status object bank
// assumes an apb master with 16-bit byte addresses and 32-bit data

package esob_pkg;

  // ----------------------------------------------------------------
  // object indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_DEVICE_ID    = 16'h1000;
  localparam logic [15:0] IDX_ERR_SUMMARY  = 16'h1001;
  localparam logic [15:0] IDX_HIST_COUNT   = 16'h1003;
  // entries have no index of their own: position n sits at base + 4*(n-1)
  localparam logic [15:0] ADDR_ENTRY_BASE  = 16'h4020;
  localparam logic [15:0] ADDR_ENTRY_LAST  = 16'h403c;

  // ----------------------------------------------------------------
  // identification word fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  MOTOR_BLDC       = 8'h02;
  localparam logic [7:0]  MOTOR_STEPPER    = 8'h04;
  localparam logic [7:0]  MOTOR_BOTH       = 8'h06;
  // arbitrary neutral profile number
  localparam logic [15:0] PROFILE_DEFAULT  = 16'h0abc;

  // ----------------------------------------------------------------
  // summary register bit positions and reset values
  // ----------------------------------------------------------------
  localparam int          SUM_GENERAL      = 0;
  localparam int          SUM_CURRENT      = 1;
  localparam int          SUM_VOLTAGE      = 2;
  localparam int          SUM_TEMPERATURE  = 3;
  localparam int          SUM_COMMS        = 4;
  localparam int          SUM_PROFILE      = 5;
  localparam int          SUM_RESERVED     = 6;
  localparam int          SUM_VENDOR       = 7;
  localparam logic [7:0]  SUM_RESET        = 8'h00;
  localparam logic [7:0]  COUNT_RESET      = 8'h00;
  localparam logic [31:0] ENTRY_RESET      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // history and answers
  // ----------------------------------------------------------------
  localparam logic [7:0]  HIST_DEPTH       = 8'h08;
  localparam logic [31:0] ABORT_NO_ENTRY   = 32'h0800_0024;
  localparam logic [31:0] RDATA_NONE       = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic vendor_fault_flag;
    logic profile_fault_flag;
    logic comms_fault_flag;
    logic temperature_fault_flag;
    logic voltage_fault_flag;
    logic current_fault_flag;
    logic general_fault_flag;
  } esob_fault_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  number;
    logic [15:0] code;
  } esob_err_evt_s;

  typedef enum logic [2:0] {
    T_NONE  = 3'b000,
    T_ID    = 3'b001,
    T_SUM   = 3'b010,
    T_CNT   = 3'b011,
    T_ENTRY = 3'b100
  } esob_target_e;

endpackage : esob_pkg

// ===== design/esob_history.sv
// eight-deep error history stack with a saturating entry counter
// assumes push and clear come from logic on the same clock

`timescale 1ns/1ps

module esob_history
  import esob_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // update side
  input  wire logic        push,
  input  wire logic [31:0] push_entry,
  input  wire logic        clear,
  // read side
  input  wire logic [2:0]  rd_idx,
  output logic      [31:0] rd_entry,
  output logic      [7:0]  count_q
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0] mem_q [0:7];
  logic [31:0] mem_d [0:7];
  logic [7:0]  count_d;

  // next state: clear first, then a push on top so a push is never lost
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      mem_d[i] = mem_q[i];
    end
    count_d = count_q;
    if (clear) begin
      for (int i = 0; i < 8; i++) begin
        mem_d[i] = ENTRY_RESET;
      end
      count_d = COUNT_RESET;
    end
    if (push) begin
      // newest at position 1, older ones move back one place
      for (int i = 7; i > 0; i--) begin
        mem_d[i] = clear ? ENTRY_RESET : mem_q[i-1];
      end
      mem_d[0] = push_entry;
      if (clear) begin
        count_d = 8'h01;
      end else if (count_q < HIST_DEPTH) begin
        count_d = count_q + 8'h01;
      end
    end
  end

  // registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        mem_q[i] <= ENTRY_RESET;
      end
      count_q <= COUNT_RESET;
    end else begin
      for (int i = 0; i < 8; i++) begin
        mem_q[i] <= mem_d[i];
      end
      count_q <= count_d;
    end
  end

  // read port, 0-based index for positions 1 to 8
  assign rd_entry = mem_q[rd_idx];

endmodule : esob_history

// ===== design/esob_bank.sv
// apb register bank: identification word, error summary and error history
// assumes fault levels arrive asynchronously and error events on this clock
//
// The APB interface to the registers is this design's own decision.

`timescale 1ns/1ps

// What this block does
// - a read-only 32-bit identification word carries the motor type above and the profile number below.
// - bits 23 to 16 of that word hold 2 for brushless, 4 for stepper or 6 for both.
// - an 8-bit read-only summary starts at zero and follows each error class while it is present.
// - summary bits are general, current, voltage, temperature, comms, profile, reserved zero, vendor.
// - the history holds eight 32-bit entries at positions 1 to 8 and an 8-bit count at 0, reset to zero.
// - a new error goes to position 1 and the older entries move back one place.
// - reading the count returns how many errors are recorded.
// - with an empty history any read of positions 1 to 8 is refused with the abort code.
// - writing zero to the low byte of the count with its strobe set clears it and counting starts over.
// - an entry is error number in 31 to 24, class in 23 to 16 and code in 15 to 0.
// - the class byte of an entry equals the summary at the moment the error is recorded.
module esob_bank
  import esob_pkg::*;
#(
  parameter logic [7:0]  MOTOR_TYPE  = MOTOR_BOTH,
  parameter logic [15:0] PROFILE_NUM = PROFILE_DEFAULT
)
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          nrst,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [15:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic               pready,
  output logic      [31:0]   prdata,
  output logic               pslverr,
  // fault conditions, asynchronous levels
  input  wire esob_fault_s   fault_in,
  // error events from the controller logic
  input  wire esob_err_evt_s err_evt,
  // status
  output logic      [7:0]    summary_out,
  output logic      [7:0]    history_count_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // byte address of an object index
  function automatic logic [15:0] idx_to_addr(input logic [15:0] idx);
    idx_to_addr = {idx[13:0], 2'b00};
  endfunction : idx_to_addr

  // which object an address selects
  function automatic esob_target_e decode(input logic [15:0] addr);
    if (addr == idx_to_addr(IDX_DEVICE_ID)) begin
      decode = T_ID;
    end else if (addr == idx_to_addr(IDX_ERR_SUMMARY)) begin
      decode = T_SUM;
    end else if (addr == idx_to_addr(IDX_HIST_COUNT)) begin
      decode = T_CNT;
    end else if (addr >= ADDR_ENTRY_BASE && addr <= ADDR_ENTRY_LAST && addr[1:0] == 2'b00) begin
      decode = T_ENTRY;
    end else begin
      decode = T_NONE;
    end
  endfunction : decode

  // zero in the low byte of a count write, the only value the count takes
  function automatic logic low_byte_zero(input logic [31:0] data);
    low_byte_zero = (data[7:0] == 8'h00);
  endfunction : low_byte_zero

  // ----------------------------------------------------------------
  // address map, byte addresses
  // ----------------------------------------------------------------
  // 0x4000 identification word, read only
  // 0x4004 error summary in bits 7 to 0, read only
  // 0x400c history count in bits 7 to 0, a write with pstrb[0] set is taken only if its low byte is zero
  // 0x4020 to 0x403c history positions 1 to 8, read only
  // any other address answers with an error and zero data

  // ----------------------------------------------------------------
  // fault level synchroniser
  // ----------------------------------------------------------------
  esob_fault_s sync1_q;
  esob_fault_s sync2_q;

  // first stage feeds only the second, to keep metastability contained
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= fault_in;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // error summary
  // ----------------------------------------------------------------
  logic [7:0] summary_q;
  logic [7:0] summary_d;

  // each bit mirrors its condition, so it clears itself when it goes away
  always_comb begin
    summary_d                  = SUM_RESET;
    summary_d[SUM_GENERAL]     = sync2_q.general_fault_flag;
    summary_d[SUM_CURRENT]     = sync2_q.current_fault_flag;
    summary_d[SUM_VOLTAGE]     = sync2_q.voltage_fault_flag;
    summary_d[SUM_TEMPERATURE] = sync2_q.temperature_fault_flag;
    summary_d[SUM_COMMS]       = sync2_q.comms_fault_flag;
    summary_d[SUM_PROFILE]     = sync2_q.profile_fault_flag;
    summary_d[SUM_RESERVED]    = 1'b0;
    summary_d[SUM_VENDOR]      = sync2_q.vendor_fault_flag;
  end

  // register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      summary_q <= SUM_RESET;
    end else begin
      summary_q <= summary_d;
    end
  end

  assign summary_out = summary_q;

  // ----------------------------------------------------------------
  // identification word
  // ----------------------------------------------------------------
  logic [31:0] ident_word;

  // upper half motor type, lower half profile; top byte unused
  assign ident_word = {8'h00, MOTOR_TYPE, PROFILE_NUM};

  // ----------------------------------------------------------------
  // history stack
  // ----------------------------------------------------------------
  logic        hist_push;
  logic [31:0] hist_entry;
  logic        hist_clear;
  logic [2:0]  hist_rd_idx;
  logic [31:0] hist_rd_entry;
  logic [7:0]  hist_count;

  // class byte taken from the summary as it stands in the event cycle
  assign hist_push  = err_evt.valid;
  assign hist_entry = {err_evt.number, summary_q, err_evt.code};

  esob_history u_history (
    .clock      (clock),
    .nrst       (nrst),
    .push       (hist_push),
    .push_entry (hist_entry),
    .clear      (hist_clear),
    .rd_idx     (hist_rd_idx),
    .rd_entry   (hist_rd_entry),
    .count_q    (hist_count)
  );

  assign history_count_out = hist_count;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic         pready_q;
  logic         pready_d;
  logic [31:0]  prdata_q;
  logic [31:0]  prdata_d;
  logic         pslverr_q;
  logic         pslverr_d;
  logic         setup_phase;
  logic         access_done;
  esob_target_e target;
  logic [15:0]  entry_off;

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_q;
  assign target      = decode(paddr);
  assign entry_off   = paddr - ADDR_ENTRY_BASE;
  assign hist_rd_idx = entry_off[4:2];

  // answer prepared in the setup cycle, so every transfer has no wait state
  always_comb begin
    pready_d  = pready_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (setup_phase) begin
      pready_d  = 1'b1;
      prdata_d  = RDATA_NONE;
      pslverr_d = 1'b0;
      if (pwrite) begin
        // only the count takes writes, and with pstrb[0] set only a zero low byte
        if (target != T_CNT) begin
          pslverr_d = 1'b1;
        end else if (pstrb[0] && !low_byte_zero(pwdata)) begin
          pslverr_d = 1'b1;
        end
      end else begin
        unique case (target)
          T_ID: begin
            prdata_d = ident_word;
          end
          T_SUM: begin
            prdata_d = {24'h00_0000, summary_q};
          end
          T_CNT: begin
            prdata_d = {24'h00_0000, hist_count};
          end
          T_ENTRY: begin
            if (hist_count == COUNT_RESET) begin
              prdata_d  = ABORT_NO_ENTRY;
              pslverr_d = 1'b1;
            end else begin
              prdata_d = hist_rd_entry;
            end
          end
          T_NONE: begin
            pslverr_d = 1'b1;
          end
          default: begin
            pslverr_d = 1'b1;
          end
        endcase
      end
    end else if (access_done) begin
      // release the answer after the completing edge
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      prdata_d  = RDATA_NONE;
    end
  end

  // a zero written to the count's low byte, with pstrb[0] set, at the completing edge clears the history
  assign hist_clear = access_done && pwrite && target == T_CNT && pstrb[0] && low_byte_zero(pwdata);

  // registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready_q  <= 1'b0;
      prdata_q  <= RDATA_NONE;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

endmodule : esob_bank

// ===== test/esob_bank_sva.sv
// port checker of the object bank, bound into esob_bank
// assumes one clock and the zero-wait apb answer of the bank
`timescale 1ns/1ps
module esob_bank_sva
  import esob_pkg::*;
#(
  parameter logic [7:0]  MOTOR_TYPE  = MOTOR_BOTH,
  parameter logic [15:0] PROFILE_NUM = PROFILE_DEFAULT
)
(
  // clock and reset
  input wire logic          clock,
  input wire logic          nrst,
  // apb slave side
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [15:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [3:0]    pstrb,
  input wire logic          pready,
  input wire logic [31:0]   prdata,
  input wire logic          pslverr,
  // faults, events, status
  input wire esob_fault_s   fault_in,
  input wire esob_err_evt_s err_evt,
  input wire logic [7:0]    summary_out,
  input wire logic [7:0]    history_count_out
);
  // ----------------------------------------------------------------
  // helper terms
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic setup_rd;
  logic clr_wr;
  // a zero write to the count with its low strobe clears the stack
  assign setup_rd = psel && !penable && !pwrite;
  assign clr_wr   = psel && penable && pready && pwrite && paddr == 16'h400c && pstrb[0] && pwdata[7:0] == 8'h00;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  answer_next_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("answer not one cycle after setup");
  idle_quiet_a: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read bus not quiet between answers");
  id_word_a: assert property (setup_rd && paddr == 16'h4000 |=> prdata == {8'h00, MOTOR_TYPE, PROFILE_NUM})
    else $error("identification word wrong");
  summary_read_a: assert property (setup_rd && paddr == 16'h4004 |=> prdata == {24'h00_0000, $past(summary_out)})
    else $error("summary read differs from summary");
  reserved_zero_a: assert property (summary_out[SUM_RESERVED] == 1'b0)
    else $error("reserved summary bit set");
  count_read_a: assert property (setup_rd && paddr == 16'h400c |=> prdata == {24'h00_0000, $past(history_count_out)})
    else $error("count read differs from count");
  empty_abort_a: assert property (setup_rd && paddr >= 16'h4020 && paddr <= 16'h403c && paddr[1:0] == 2'b00
    && history_count_out == 8'h00 |=> pslverr && prdata == ABORT_NO_ENTRY)
    else $error("empty stack read not aborted");
  count_step_a: assert property (err_evt.valid && history_count_out < HIST_DEPTH && !clr_wr
    |=> history_count_out == $past(history_count_out) + 8'h01)
    else $error("count did not step on event");
  count_sat_a: assert property (err_evt.valid && history_count_out == HIST_DEPTH |=> history_count_out == HIST_DEPTH)
    else $error("count left eight");
  count_clear_a: assert property (clr_wr && !err_evt.valid |=> history_count_out == 8'h00)
    else $error("zero write did not clear count");
  clr_evt_a: assert property (clr_wr && err_evt.valid |=> history_count_out == 8'h01)
    else $error("event lost when it met a clear");
endmodule : esob_bank_sva

bind esob_bank esob_bank_sva #(.MOTOR_TYPE(MOTOR_TYPE), .PROFILE_NUM(PROFILE_NUM)) u_sva (
  .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .fault_in(fault_in), .err_evt(err_evt), .summary_out(summary_out), .history_count_out(history_count_out));

// ===== test/esob_apb_master.sv
// apb master standing in for the fieldbus side of the bank
// assumes the bench calls xfer from one process only
`timescale 1ns/1ps
module esob_apb_master (
  // clock
  input  wire logic        clock,
  // answer from the slave
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  // request to the slave
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [15:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb
);
  // idle bus at time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end
  // one transfer; request held until pready is seen, only the bench watchdog ends a hang
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : esob_apb_master

// ===== test/tb_top.sv
// self-checking bench of the error and status object bank
// assumes the bank answers apb and takes events on one clock
`timescale 1ns/1ps
module tb_top
  import esob_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and models
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic nrst;
  logic psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  esob_fault_s fault_in;
  esob_err_evt_s err_evt;
  logic [7:0] summary_out, history_count_out;
  logic [31:0] rng_q = 32'h0000_0008;
  logic [31:0] hist[$];
  logic [31:0] ev_r;
  int failures = 0;
  int samples_checked = 0;
  always #12.5 clock = ~clock;
  esob_bank uut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .fault_in(fault_in), .err_evt(err_evt), .summary_out(summary_out),
    .history_count_out(history_count_out));
  esob_apb_master m (.clock(clock), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rng_q ^= rng_q << 13;
    rng_q ^= rng_q >> 17;
    rng_q ^= rng_q << 5;
    return rng_q;
  endfunction : rnd
  // reserved bit 6 sits between vendor and the six low classes
  function automatic logic [7:0] exp_sum(input esob_fault_s f);
    return {f.vendor_fault_flag, 1'b0, f[5:0]};
  endfunction : exp_sum
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [31:0] exp, input logic ee);
    logic [31:0] rd;
    logic e;
    m.xfer(w, a, d, s, rd, e);
    if (!w) chk("prdata", rd, exp);
    chk("pslverr", {31'h0, e}, {31'h0, ee});
  endtask : acc
  // events back to back; the queue mirrors the stack, newest first
  task automatic push(input int n);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      r = rnd();
      @(posedge clock);
      err_evt <= {1'b1, r[31:24], r[15:0]};
      hist.push_front({r[31:24], exp_sum(fault_in), r[15:0]});
      if (hist.size() > 8) void'(hist.pop_back());
    end
    @(posedge clock);
    err_evt <= '0;
    @(posedge clock);
    chk("history_count_out", {24'h0, history_count_out}, hist.size());
    acc(1'b0, 16'h400c, 0, 4'h0, hist.size(), 1'b0);
    foreach (hist[i]) acc(1'b0, 16'h4020 + 16'(4 * i), 0, 4'h0, hist[i], 1'b0);
  endtask : push
  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #(25 * 5000);
    failures++;
    tally_and_finish();
  end
  initial begin
    nrst = 1'b0;
    fault_in = '0;
    err_evt = '0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    acc(1'b0, 16'h4000, 0, 4'h0, {8'h00, MOTOR_BOTH, PROFILE_DEFAULT}, 1'b0);
    acc(1'b0, 16'h400c, 0, 4'h0, 32'h0000_0000, 1'b0);
    acc(1'b0, 16'h4020, 0, 4'h0, ABORT_NO_ENTRY, 1'b1);
    acc(1'b0, 16'h403c, 0, 4'h0, ABORT_NO_ENTRY, 1'b1);
    acc(1'b1, 16'h4000, rnd(), 4'hf, 0, 1'b1);
    acc(1'b1, 16'h4004, rnd(), 4'hf, 0, 1'b1);
    acc(1'b1, 16'h4008, rnd(), 4'hf, 0, 1'b1);
    // unmapped and unaligned reads answer an error with zero data
    acc(1'b0, 16'h4008, 0, 4'h0, 32'h0000_0000, 1'b1);
    acc(1'b0, 16'h4022, 0, 4'h0, 32'h0000_0000, 1'b1);
    // fault levels, all ones first, last pass clears them
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      fault_in <= (i == 0) ? 7'h7f : (i == 4) ? 7'h00 : 7'(rnd());
      repeat (4) @(posedge clock);
      chk("summary_out", {24'h0, summary_out}, {24'h0, exp_sum(fault_in)});
      acc(1'b0, 16'h4004, 0, 4'h0, {24'h0, exp_sum(fault_in)}, 1'b0);
    end
    @(posedge clock);
    fault_in <= 7'(rnd());
    repeat (4) @(posedge clock);
    push(10);
    acc(1'b1, 16'h400c, 32'h0000_0005, 4'h1, 0, 1'b1);
    acc(1'b1, 16'h400c, 32'h0000_0000, 4'h0, 0, 1'b0);
    acc(1'b0, 16'h400c, 0, 4'h0, 32'h0000_0008, 1'b0);
    acc(1'b1, 16'h400c, 32'h0000_0000, 4'h1, 0, 1'b0);
    acc(1'b0, 16'h4020, 0, 4'h0, ABORT_NO_ENTRY, 1'b1);
    hist.delete();
    push(3);
    // clear and event on one edge: the event survives alone at position 1
    ev_r = rnd();
    fork
      acc(1'b1, 16'h400c, 32'h0000_0000, 4'h1, 0, 1'b0);
      begin
        repeat (2) @(posedge clock);
        err_evt <= {1'b1, ev_r[31:24], ev_r[15:0]};
        @(posedge clock);
        err_evt <= '0;
      end
    join
    hist.delete();
    hist.push_front({ev_r[31:24], exp_sum(fault_in), ev_r[15:0]});
    push(0);
    acc(1'b0, 16'h4024, 0, 4'h0, 32'h0000_0000, 1'b0);
    // reset in mid-run empties the history again
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    chk("history_count_out", {24'h0, history_count_out}, 32'h0000_0000);
    nrst <= 1'b1;
    acc(1'b0, 16'h4020, 0, 4'h0, ABORT_NO_ENTRY, 1'b1);
    tally_and_finish();
  end
endmodule : tb_top
